// [core/ephy_host.sv]
// host end driving a controller's external gmii/mii port as its phy
`timescale 1ns/1ps
`include "ephy_params.svh"
module ephy_host import ephy_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic phy_clk,
  input wire logic mode_gig,
  input wire logic link_up,
  input wire logic col_in,
  input wire logic crs_in,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [15:0] cmd_len,
  input wire logic [7:0] cmd_first,
  input wire logic cmd_err_en,
  input wire logic [15:0] cmd_err_pos,
  output logic rep_valid,
  output logic [15:0] rep_count,
  output logic [15:0] rep_sum,
  output logic rep_err,
  output logic rep_ext,
  output logic ext_mode_select_a,
  output logic ext_mode_select_b,
  output logic link_indication_input,
  output logic col,
  output logic crs,
  output logic rx_clk,
  output logic mii_transmit_clock_input,
  output logic [7:0] rx_data,
  output logic rx_dv,
  output logic rx_er,
  input wire logic [7:0] tx_data,
  input wire logic tx_en,
  input wire logic tx_er
);
  // ---------------- system clock side ----------------
  logic next_mode_a, next_mode_b, next_link, next_col, next_crs;
  logic next_rep_valid;
  ephy_sum_t rep, next_rep;
  logic sum_valid;
  ephy_sum_t sum_word;
  ephy_cmd_t cmd_word;

  assign cmd_word = '{len: cmd_len, first: cmd_first, err_en: cmd_err_en,
                      err_pos: cmd_err_pos};
  assign rep_count = rep.count;
  assign rep_sum = rep.sum;
  assign rep_err = rep.err;
  assign rep_ext = rep.ext;

  always_comb begin
    next_mode_a = `EPHY_MODE_A_ON;
    next_mode_b = `EPHY_MODE_B_ON;
    next_link = link_up;
    next_col = col_in;
    next_crs = crs_in;
    next_rep_valid = sum_valid;
    next_rep = sum_valid ? sum_word : rep;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_mode_select_a <= `EPHY_MODE_A_ON;
      ext_mode_select_b <= `EPHY_MODE_B_ON;
      link_indication_input <= 1'b0;
      col <= 1'b0;
      crs <= 1'b0;
      rep_valid <= 1'b0;
      rep <= '0;
    end else begin
      ext_mode_select_a <= next_mode_a;
      ext_mode_select_b <= next_mode_b;
      link_indication_input <= next_link;
      col <= next_col;
      crs <= next_crs;
      rep_valid <= next_rep_valid;
      rep <= next_rep;
    end
  end

  // ---------------- link clock side ----------------
  // the phy end makes both link clocks; the device's own gigabit
  // transmit clock is not taken, so gigabit transmit is sampled here
  // on the forwarded receive clock and needs a frequency-locked device
  assign rx_clk = phy_clk;
  assign mii_transmit_clock_input = phy_clk;
  // no management pins: phy registers are never reached from here

  logic link_rst_m, link_rst;
  logic gig_m, gig_l;
  logic next_link_rst_m, next_link_rst, next_gig_m, next_gig_l;

  always_comb begin
    next_link_rst_m = reset;
    next_link_rst = link_rst_m;
    next_gig_m = mode_gig;
    next_gig_l = gig_m;
  end

  // reset and mode pass two flops; the first feeds only the second
  always_ff @(posedge phy_clk) begin
    link_rst_m <= next_link_rst_m;
    link_rst <= next_link_rst;
    gig_m <= next_gig_m;
    gig_l <= next_gig_l;
  end

  logic cmd_l_valid, cmd_l_ready, cmd_take;
  ephy_cmd_t cmd_l;
  logic [7:0] cmd_first_l;

  ephy_xfer #(.W(`EPHY_CMD_W)) u_cmd_xfer (
    .clk_a(mclk),
    .rst_a(reset),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_word),
    .clk_b(phy_clk),
    .rst_b(link_rst),
    .out_valid(cmd_l_valid),
    .out_ready(cmd_l_ready),
    .out_data(cmd_l)
  );

  ephy_gen_state_t gen_state, next_gen_state;
  logic gen_gig, next_gen_gig;
  logic phase, next_phase;
  logic [7:0] val, next_val;
  logic [`EPHY_CNT_W-1:0] left, next_left, idx, next_idx, epos, next_epos;
  logic een, next_een;
  logic [7:0] next_rx_data;
  logic next_rx_dv, next_rx_er;
  logic step;

  assign cmd_l_ready = (gen_state == EPHY_GEN_IDLE);
  assign cmd_take = cmd_l_valid && cmd_l_ready && (cmd_l.len != '0);
  assign cmd_first_l = cmd_l.first;
  // a byte completes each cycle on gigabit, every second on the nibble path
  assign step = gen_gig || phase;

  always_comb begin
    next_gen_state = gen_state;
    next_gen_gig = gen_gig;
    next_phase = phase;
    next_val = val;
    next_left = left;
    next_idx = idx;
    next_epos = epos;
    next_een = een;
    next_rx_dv = 1'b0;
    next_rx_er = 1'b0;
    next_rx_data = 8'h00;
    unique case (gen_state)
      EPHY_GEN_IDLE: begin
        if (cmd_take) begin
          next_gen_state = EPHY_GEN_SEND;
          next_gen_gig = gig_l;
          next_phase = 1'b0;
          next_val = cmd_l.first;
          next_left = cmd_l.len;
          next_idx = '0;
          next_epos = cmd_l.err_pos;
          next_een = cmd_l.err_en;
        end
      end
      EPHY_GEN_SEND: begin
        next_rx_dv = 1'b1;
        next_rx_er = een && (idx == epos);
        if (gen_gig) begin
          next_rx_data = val;
        end else begin
          next_rx_data = {4'h0, phase ? val[7:4] : val[3:0]};
          next_phase = ~phase;
        end
        if (step) begin
          next_val = 8'(val + 8'h01);
          next_idx = ephy_inc(idx);
          next_left = `EPHY_CNT_W'(left - 16'h0001);
          if (left == 16'h0001) begin
            next_gen_state = EPHY_GEN_IDLE;
          end
        end
      end
      default: begin
        next_gen_state = EPHY_GEN_IDLE;
      end
    endcase
  end

  // receive outputs launch on the rising link edge the
  // device samples a full period later, trading hold margin for simplicity
  always_ff @(posedge phy_clk) begin
    if (link_rst) begin
      gen_state <= EPHY_GEN_IDLE;
      gen_gig <= 1'b0;
      phase <= 1'b0;
      val <= 8'h00;
      left <= '0;
      idx <= '0;
      epos <= '0;
      een <= 1'b0;
      rx_data <= 8'h00;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else begin
      gen_state <= next_gen_state;
      gen_gig <= next_gen_gig;
      phase <= next_phase;
      val <= next_val;
      left <= next_left;
      idx <= next_idx;
      epos <= next_epos;
      een <= next_een;
      rx_data <= next_rx_data;
      rx_dv <= next_rx_dv;
      rx_er <= next_rx_er;
    end
  end

  ephy_sum_if u_sum ();

  ephy_txmon u_txmon (
    .clk(phy_clk),
    .rst(link_rst),
    .gig(gig_l),
    .tx_data(tx_data),
    .tx_en(tx_en),
    .tx_er(tx_er),
    .sum_o(u_sum.src)
  );

  ephy_xfer #(.W(`EPHY_SUM_W)) u_sum_xfer (
    .clk_a(phy_clk),
    .rst_a(link_rst),
    .in_valid(u_sum.valid),
    .in_ready(u_sum.ready),
    .in_data(u_sum.sum),
    .clk_b(mclk),
    .rst_b(reset),
    .out_valid(sum_valid),
    .out_ready(1'b1),
    .out_data(sum_word)
  );

  // ---------------- checks ----------------
  sequence s_take;
    cmd_take;
  endsequence

  sequence s_nib_pair;
    rx_dv ##1 rx_dv;
  endsequence

  sequence s_one_byte;
    rx_dv ##1 !rx_dv;
  endsequence

  a_mode_strap_held: assert property (
    @(posedge mclk) disable iff (reset)
    ext_mode_select_a && !ext_mode_select_b)
    else $error("mode selects not strapped for external mode");

  a_link_follows_user: assert property (
    @(posedge mclk) disable iff (reset)
    1'b1 |=> (link_indication_input == $past(link_up)))
    else $error("link indication does not follow link_up");

  a_col_follows_user: assert property (
    @(posedge mclk) disable iff (reset)
    col_in ##1 col_in |-> col)
    else $error("collision not driven");

  a_crs_rise_cause: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(crs) |-> $past(crs_in))
    else $error("carrier sense rose without request");

  a_first_byte_out: assert property (
    @(posedge phy_clk) disable iff (link_rst)
    s_take ##1 gen_gig |=> rx_dv && rx_data == $past(cmd_first_l, 2))
    else $error("first gigabit byte wrong");

  a_mii_upper_zero: assert property (
    @(posedge phy_clk) disable iff (link_rst)
    rx_dv && !gen_gig |-> rx_data[7:4] == 4'h0)
    else $error("nibble mode drove upper data bits");

  a_mii_nibble_pair: assert property (
    @(posedge phy_clk) disable iff (link_rst)
    $rose(rx_dv) && !gen_gig |-> s_nib_pair)
    else $error("nibble frame shorter than one byte");

  a_single_byte_len: assert property (
    @(posedge phy_clk) disable iff (link_rst)
    s_take ##0 (cmd_l.len == 16'h0001) ##1 gen_gig |=> s_one_byte)
    else $error("one-byte frame has wrong valid length");

  a_err_in_frame: assert property (
    @(posedge phy_clk) disable iff (link_rst)
    rx_er |-> rx_dv)
    else $error("receive error outside a frame");

endmodule : ephy_host

// [core/ephy_params.svh]
// constants for the external gmii/mii host port
`ifndef EPHY_PARAMS_SVH
`define EPHY_PARAMS_SVH
`define EPHY_CNT_W 16
`define EPHY_BYTE_W 8
`define EPHY_NIB_W 4
`define EPHY_MODE_A_ON 1'b1
`define EPHY_MODE_B_ON 1'b0
`define EPHY_RST_LINK 1'b0
`define EPHY_CMD_W 41
`define EPHY_SUM_W 34
`endif

// [core/ephy_pkg.sv]
// types and helpers shared by the external gmii/mii host port
package ephy_pkg;
`include "ephy_params.svh"

  typedef struct packed {
    logic [`EPHY_CNT_W-1:0] len;
    logic [`EPHY_BYTE_W-1:0] first;
    logic err_en;
    logic [`EPHY_CNT_W-1:0] err_pos;
  } ephy_cmd_t;

  typedef struct packed {
    logic [`EPHY_CNT_W-1:0] count;
    logic [`EPHY_CNT_W-1:0] sum;
    logic err;
    logic ext;
  } ephy_sum_t;

  typedef enum logic [1:0] {
    EPHY_GEN_IDLE = 2'b00,
    EPHY_GEN_SEND = 2'b01
  } ephy_gen_state_t;

  function automatic logic [`EPHY_CNT_W-1:0] ephy_add8(
    input logic [`EPHY_CNT_W-1:0] acc,
    input logic [`EPHY_BYTE_W-1:0] b);
    return `EPHY_CNT_W'(acc + {8'h00, b});
  endfunction : ephy_add8

  function automatic logic [`EPHY_CNT_W-1:0] ephy_inc(
    input logic [`EPHY_CNT_W-1:0] v);
    return `EPHY_CNT_W'(v + 16'h0001);
  endfunction : ephy_inc

endpackage : ephy_pkg

// [core/ephy_sum_if.sv]
// carrier for a frame summary leaving the transmit monitor
`timescale 1ns/1ps
interface ephy_sum_if import ephy_pkg::*;;
  logic valid;
  logic ready;
  ephy_sum_t sum;
  modport src (output valid, output sum, input ready);
  modport dst (input valid, input sum, output ready);
endinterface : ephy_sum_if

// [core/ephy_txmon.sv]
// samples the device transmit pins and summarises each frame
`timescale 1ns/1ps
module ephy_txmon import ephy_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic gig,
  input wire logic [7:0] tx_data,
  input wire logic tx_en,
  input wire logic tx_er,
  ephy_sum_if.src sum_o
);
  logic [7:0] p1_data, p2_data, next_p1_data, next_p2_data;
  logic p1_en, p2_en, p1_er, p2_er;
  logic next_p1_en, next_p2_en, next_p1_er, next_p2_er;
  logic in_frame, next_in_frame;
  logic phase, next_phase;
  logic [3:0] lo_nib, next_lo_nib;
  logic [`EPHY_CNT_W-1:0] cnt, sum, next_cnt, next_sum;
  logic err, ext, next_err, next_ext;
  logic valid, next_valid;
  ephy_sum_t out_sum, next_out_sum;

  assign sum_o.valid = valid;
  assign sum_o.sum = out_sum;

  always_comb begin
    logic [`EPHY_CNT_W-1:0] b_cnt;
    logic [`EPHY_CNT_W-1:0] b_sum;
    logic b_err;
    b_cnt = in_frame ? cnt : '0;
    b_sum = in_frame ? sum : '0;
    b_err = in_frame ? err : 1'b0;
    next_p1_data = tx_data;
    next_p1_en = tx_en;
    next_p1_er = tx_er;
    next_p2_data = p1_data;
    next_p2_en = p1_en;
    next_p2_er = p1_er;
    next_in_frame = in_frame;
    next_phase = phase;
    next_lo_nib = lo_nib;
    next_cnt = cnt;
    next_sum = sum;
    next_err = err;
    next_ext = ext;
    next_valid = 1'b0;
    next_out_sum = out_sum;
    if (p2_en) begin
      next_in_frame = 1'b1;
      if (!in_frame) begin
        next_ext = 1'b0;
        next_phase = 1'b0;
      end
      if (gig) begin
        next_cnt = ephy_inc(b_cnt);
        next_sum = ephy_add8(b_sum, p2_data);
        next_err = b_err | p2_er;
      end else if (phase && in_frame) begin
        // low nibble travels first on the narrow path
        next_cnt = ephy_inc(b_cnt);
        next_sum = ephy_add8(b_sum, {p2_data[3:0], lo_nib});
        next_err = b_err;
        next_phase = 1'b0;
      end else begin
        next_cnt = b_cnt;
        next_sum = b_sum;
        next_err = b_err;
        next_lo_nib = p2_data[3:0];
        next_phase = 1'b1;
      end
    end else if (gig && p2_er && in_frame) begin
      next_ext = 1'b1;
    end else if (in_frame) begin
      // a dangling nibble is dropped
      next_in_frame = 1'b0;
      next_valid = 1'b1;
      next_out_sum = '{count: cnt, sum: sum, err: err, ext: ext};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      p1_data <= 8'h00;
      p2_data <= 8'h00;
      p1_en <= 1'b0;
      p2_en <= 1'b0;
      p1_er <= 1'b0;
      p2_er <= 1'b0;
      in_frame <= 1'b0;
      phase <= 1'b0;
      lo_nib <= 4'h0;
      cnt <= '0;
      sum <= '0;
      err <= 1'b0;
      ext <= 1'b0;
      valid <= 1'b0;
      out_sum <= '0;
    end else begin
      p1_data <= next_p1_data;
      p2_data <= next_p2_data;
      p1_en <= next_p1_en;
      p2_en <= next_p2_en;
      p1_er <= next_p1_er;
      p2_er <= next_p2_er;
      in_frame <= next_in_frame;
      phase <= next_phase;
      lo_nib <= next_lo_nib;
      cnt <= next_cnt;
      sum <= next_sum;
      err <= next_err;
      ext <= next_ext;
      valid <= next_valid;
      out_sum <= next_out_sum;
    end
  end

  a_summary_on_end: assert property (
    @(posedge clk) disable iff (rst)
    in_frame && !p2_en && !(gig && p2_er) |=> valid)
    else $error("frame end produced no summary");

endmodule : ephy_txmon

// [core/ephy_xfer.sv]
// toggle handshake carrying one word between two clock domains
`timescale 1ns/1ps
module ephy_xfer #(
  parameter int W = 8
) (
  input wire logic clk_a,
  input wire logic rst_a,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  input wire logic clk_b,
  input wire logic rst_b,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic req_t, ack_m, ack_s;
  logic [W-1:0] hold;
  logic next_req_t, next_ack_m, next_ack_s;
  logic [W-1:0] next_hold;
  logic ack_t, req_m, req_s;
  logic next_ack_t, next_req_m, next_req_s;

  // source side holds the word until the far side has toggled back
  assign in_ready = (req_t == ack_s);

  always_comb begin
    next_ack_m = ack_t;
    next_ack_s = ack_m;
    next_req_t = req_t;
    next_hold = hold;
    if (in_valid && in_ready) begin
      next_req_t = ~req_t;
      next_hold = in_data;
    end
  end

  always_ff @(posedge clk_a) begin
    if (rst_a) begin
      req_t <= 1'b0;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      hold <= '0;
    end else begin
      req_t <= next_req_t;
      ack_m <= next_ack_m;
      ack_s <= next_ack_s;
      hold <= next_hold;
    end
  end

  // hold is static while a request is open, so reading it here is safe
  assign out_valid = (req_s != ack_t);
  assign out_data = hold;

  always_comb begin
    next_req_m = req_t;
    next_req_s = req_m;
    next_ack_t = ack_t;
    if (out_valid && out_ready) begin
      next_ack_t = ~ack_t;
    end
  end

  always_ff @(posedge clk_b) begin
    if (rst_b) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      ack_t <= 1'b0;
    end else begin
      req_m <= next_req_m;
      req_s <= next_req_s;
      ack_t <= next_ack_t;
    end
  end

  a_xfer_hold_stable: assert property (
    @(posedge clk_a) disable iff (rst_a)
    !in_ready |=> $stable(hold))
    else $error("crossing word changed while in flight");

endmodule : ephy_xfer

// [sim/ephy_dev.sv]
// behavioural controller that faces the host port as its external phy
`timescale 1ns/1ps
module ephy_dev (
  input wire logic gig,
  input wire logic ext_mode_select_a,
  input wire logic ext_mode_select_b,
  input wire logic link_indication_input,
  input wire logic col,
  input wire logic crs,
  input wire logic rx_clk,
  input wire logic mii_transmit_clock_input,
  input wire logic [7:0] rx_data,
  input wire logic rx_dv,
  input wire logic rx_er,
  output logic [7:0] tx_data,
  output logic tx_en,
  output logic tx_er
);
  // no management data port is modelled in this mode
  int q_cnt[$];
  int q_sum[$];
  int q_err[$];
  int cnt = 0;
  int sum = 0;
  int err = 0;
  int col_seen = 0;
  bit half = 0;
  bit dv_d = 0;
  bit tx_busy = 0;
  logic [3:0] low_nib = 4'h0;
  wire ext_on = ext_mode_select_a === 1'b1 &&
    ext_mode_select_b === 1'b0;
  wire take = ext_on && link_indication_input === 1'b1 &&
    rx_dv === 1'b1;
  // gigabit transmit clock stands in frequency-locked to the receive clock
  wire tx_clk = gig ? rx_clk :
    mii_transmit_clock_input;
  initial begin
    tx_data = 8'h00;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  always @(posedge rx_clk) begin
    if (col === 1'b1) col_seen++;
    if (take) begin
      if (rx_er === 1'b1) err = 1;
      if (gig) begin
        sum += rx_data;
        cnt++;
      end else if (half) begin
        sum += {rx_data[3:0], low_nib};
        cnt++;
        half = 0;
      end else begin
        low_nib = rx_data[3:0];
        half = 1;
      end
    end else if (dv_d) begin
      q_cnt.push_back(cnt);
      q_sum.push_back(sum);
      q_err.push_back(err);
      cnt = 0;
      sum = 0;
      err = 0;
      half = 0;
    end
    dv_d = take;
  end
  // idle data keeps moving so a stale value can never pass for data
  always @(posedge tx_clk) begin
    if (!tx_busy) tx_data <= ~tx_data;
  end
  task automatic send(input int len, input int first, input int ea,
      input int ext);
    int i;
    int k;
    logic [7:0] b;
    logic [3:0] nb;
    tx_busy = 1'b1;
    while (crs === 1'b1) @(posedge tx_clk);
    for (i = 0; i < len; i++) begin
      b = 8'(first + i);
      for (k = 0; k < (gig ? 1 : 2); k++) begin
        nb = k ? b[7:4] : b[3:0];
        @(posedge tx_clk);
        tx_en <= 1'b1;
        tx_er <= gig && i == ea;
        tx_data <= gig ? b : {~nb, nb};
      end
    end
    for (i = 0; i < (gig ? ext : 0); i++) begin
      @(posedge tx_clk);
      tx_en <= 1'b0;
      tx_er <= 1'b1;
      tx_data <= 8'h0F;
    end
    @(posedge tx_clk);
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    tx_busy = 1'b0;
  endtask : send
endmodule : ephy_dev

// [sim/testbench.sv]
// self-checking bench for the external gmii/mii host port
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic phy_clk = 1'b0;
  logic reset = 1'b1;
  logic mode_gig = 1'b1;
  logic link_up = 1'b0;
  logic col_in = 1'b0;
  logic crs_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_len = 16'h0000;
  logic [7:0] cmd_first = 8'h00;
  logic cmd_err_en = 1'b0;
  logic [15:0] cmd_err_pos = 16'h0000;
  logic cmd_ready, rep_valid, rep_err, rep_ext, mode_a, mode_b;
  logic [15:0] rep_count, rep_sum;
  logic link_ind, col, crs, rx_clk, mii_tx_clk, rx_dv, rx_er, tx_en, tx_er;
  logic [7:0] rx_data, tx_data;
  int err_total = 0;
  int tests_run = 0;
  int seed = 48;
  int cycles = 0;
  int exp_cnt[$];
  int exp_sum[$];
  int exp_err[$];
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    #3;
    forever #16 phy_clk = ~phy_clk;
  end
  ephy_host u_ephy_host (.mclk(mclk), .reset(reset), .phy_clk(phy_clk),
    .mode_gig(mode_gig), .link_up(link_up), .col_in(col_in),
    .crs_in(crs_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_len(cmd_len), .cmd_first(cmd_first), .cmd_err_en(cmd_err_en),
    .cmd_err_pos(cmd_err_pos), .rep_valid(rep_valid),
    .rep_count(rep_count), .rep_sum(rep_sum), .rep_err(rep_err),
    .rep_ext(rep_ext), .ext_mode_select_a(mode_a),
    .ext_mode_select_b(mode_b), .link_indication_input(link_ind),
    .col(col), .crs(crs), .rx_clk(rx_clk),
    .mii_transmit_clock_input(mii_tx_clk),
    .rx_data(rx_data), .rx_dv(rx_dv), .rx_er(rx_er), .tx_data(tx_data),
    .tx_en(tx_en), .tx_er(tx_er));
  ephy_dev u_ephy_dev (.gig(mode_gig), .ext_mode_select_a(mode_a),
    .ext_mode_select_b(mode_b), .link_indication_input(link_ind),
    .col(col), .crs(crs), .rx_clk(rx_clk),
    .mii_transmit_clock_input(mii_tx_clk),
    .rx_data(rx_data), .rx_dv(rx_dv), .rx_er(rx_er), .tx_data(tx_data),
    .tx_en(tx_en), .tx_er(tx_er));
  task automatic conclude;
    $display("Checks run %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // a hang counts against the run, then reports
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic send_cmd(input int len, input int first, input bit eon,
      input int pos);
    int i;
    int s = 0;
    int g = 0;
    // let an edge pass so valid never falls and rises in one step
    @(posedge mclk);
    #1;
    cmd_len = 16'(len);
    cmd_first = 8'(first);
    cmd_err_en = eon;
    cmd_err_pos = 16'(pos);
    cmd_valid = 1'b1;
    do begin
      @(posedge mclk);
      g++;
    end while (cmd_ready !== 1'b1 && g < 500);
    #1;
    cmd_valid = 1'b0;
    for (i = 0; i < len; i++) s += (first + i) % 256;
    if (len > 0) begin
      exp_cnt.push_back(len);
      exp_sum.push_back(s);
      exp_err.push_back(eon && pos < len);
    end
  endtask : send_cmd
  task automatic wait_rx;
    int g = 0;
    int a;
    do begin
      @(posedge mclk);
      g++;
    end while (u_ephy_dev.q_cnt.size() < exp_cnt.size() && g < 2000);
    #1;
    a = u_ephy_dev.q_cnt.size();
    check("rx frames", exp_cnt.size(), a);
    while (exp_cnt.size() > 0 && u_ephy_dev.q_cnt.size() > 0) begin
      a = u_ephy_dev.q_cnt.pop_front();
      check("rx bytes", exp_cnt.pop_front(), a);
      a = u_ephy_dev.q_sum.pop_front();
      check("rx sum", exp_sum.pop_front(), a);
      a = u_ephy_dev.q_err.pop_front();
      check("rx error", exp_err.pop_front(), a);
    end
    exp_cnt.delete();
    exp_sum.delete();
    exp_err.delete();
  endtask : wait_rx
  task automatic tx_frame(input int len, input int first, input int ea,
      input int ext);
    int i;
    int s = 0;
    int g = 0;
    for (i = 0; i < len; i++) s += (first + i) % 256;
    u_ephy_dev.send(len, first, ea, ext);
    do begin
      @(posedge mclk);
      #1;
      g++;
    end while (rep_valid !== 1'b1 && g < 200);
    check("rep_valid", 1, rep_valid);
    check("rep_count", len, rep_count);
    check("rep_sum", s % 65536, rep_sum);
    check("rep_err", mode_gig && ea < len, rep_err);
    check("rep_ext", mode_gig && ext > 0, rep_ext);
  endtask : tx_frame
  initial begin
    int m;
    int n;
    int len;
    // held past three link clock edges so the link side resets too
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'b0;
    check("mode a", 1, mode_a);
    check("mode b", 0, mode_b);
    check("rx_dv idle", 0, rx_dv);
    repeat (4) @(posedge phy_clk);
    @(posedge mclk);
    #1;
    for (n = 0; n < 8; n++) begin
      {link_up, col_in, crs_in} = 3'($random(seed));
      @(posedge mclk);
      #1;
      check("link", link_up, link_ind);
      check("col", col_in, col);
      check("crs", crs_in, crs);
    end
    {link_up, col_in, crs_in} = 3'b100;
    for (m = 1; m >= 0; m--) begin
      mode_gig = m[0];
      repeat (20) @(posedge mclk);
      #1;
      send_cmd(0, 255, 1'b1, 0);
      for (n = 0; n < 5; n++) begin
        // one single-byte frame per mode for the short-frame check
        len = n == 1 ? 1 : 1 + {$random(seed)} % 12;
        send_cmd(len, n == 0 ? 255 : {$random(seed)} % 256, n[0],
          {$random(seed)} % (len + 2));
      end
      wait_rx();
      for (n = 0; n < 6; n++) begin
        len = 1 + {$random(seed)} % 12;
        tx_frame(len, {$random(seed)} % 256, {$random(seed)} % (len + 2),
          n % 3);
      end
    end
    conclude();
  end
endmodule : testbench
